/* File: rpsel_defines.svh */
// constants for the remappable peripheral pin select block
// assumes inclusion by bare name from the package and the design files
`ifndef RPSEL_DEFINES_SVH
`define RPSEL_DEFINES_SVH
`define RPSEL_NUM_PINS 26
`define RPSEL_SEL_W 5
`define RPSEL_DATA_W 16
`define RPSEL_ADDR_W 6
`define RPSEL_NUM_POUT 8
`define RPSEL_POUT_W 3
`define RPSEL_TIE_LOW 5'h1f
`define RPSEL_IN_RESET 5'h1f
`define RPSEL_OUT_RESET 3'h0
`define RPSEL_ADDR_TMR 6'h00
`define RPSEL_ADDR_SPI 6'h01
`define RPSEL_ADDR_LOCK 6'h02
`define RPSEL_ADDR_OUT_BASE 6'h10
`define RPSEL_UNLOCK_KEY1 16'h0046
`define RPSEL_UNLOCK_KEY2 16'h0057
`define RPSEL_LOCK_KEY 16'h0001
`define RPSEL_T2_LSB 0
`define RPSEL_T3_LSB 8
`define RPSEL_SS_LSB 0
`endif

/* File: rpsel_pkg.sv */
// types shared by the pin select block
// assumes rpsel_defines.svh is on the include path
`include "rpsel_defines.svh"
package rpsel_pkg;
    typedef logic [`RPSEL_SEL_W-1:0] rpsel_sel_t;
    typedef logic [`RPSEL_POUT_W-1:0] rpsel_osel_t;
    typedef enum logic [2:0] {
        RPSEL_LOCKED = 3'h1,
        RPSEL_KEY1 = 3'h2,
        RPSEL_OPEN = 3'h4
    } rpsel_lock_t;
    typedef struct packed {
        rpsel_sel_t t2_sel;
        rpsel_sel_t t3_sel;
        rpsel_sel_t ss_sel;
        rpsel_osel_t [`RPSEL_NUM_PINS-1:0] out_sel;
        rpsel_lock_t lock;
        logic [`RPSEL_DATA_W-1:0] rdata;
        logic t2_in;
        logic t3_in;
        logic ss_in;
        logic [`RPSEL_NUM_PINS-1:0] pin_out;
        logic [`RPSEL_NUM_PINS-1:0] pin_oe;
    } rpsel_state_t;
endpackage

/* File: rpsel_in_mux.sv */
// one input selector: picks a remappable pin or ties low
// assumes pins are synchronous to the reference clock
`include "rpsel_defines.svh"
module rpsel_in_mux
    import rpsel_pkg::*;
(
    input wire logic [`RPSEL_NUM_PINS-1:0] i_pins,
    input wire rpsel_sel_t i_sel,
    output logic o_in
);
    always_comb
    begin
        // all-ones and codes beyond the last pin give a steady low
        if (i_sel == `RPSEL_TIE_LOW || 32'(i_sel) >= `RPSEL_NUM_PINS)
        begin
            o_in = 1'b0;
        end
        else
        begin
            o_in = i_pins[i_sel];
        end
    end
endmodule

/* File: rpsel_top.sv */
// remappable peripheral pin select: input maps, output maps, lock
// assumes a simple strobe register port and pins synchronous to i_ref_clk
`include "rpsel_defines.svh"

module rpsel_top
    import rpsel_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [`RPSEL_ADDR_W-1:0] i_addr,
    input wire logic [`RPSEL_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`RPSEL_DATA_W-1:0] o_rdata,
    input wire logic [`RPSEL_NUM_PINS-1:0] i_pin_in,
    input wire logic [`RPSEL_NUM_PINS-1:0] i_port_out,
    input wire logic [`RPSEL_NUM_PINS-1:0] i_port_oe,
    input wire logic [`RPSEL_NUM_POUT-1:0] i_periph_out,
    output logic [`RPSEL_NUM_PINS-1:0] o_pin_out,
    output logic [`RPSEL_NUM_PINS-1:0] o_pin_oe,
    output logic [`RPSEL_NUM_PINS-1:0] o_pin_remapped,
    output logic o_timer2_external_clock_input,
    output logic o_timer3_external_clock_input,
    output logic o_spi1_slave_select_input,
    output logic o_map_locked
);
    rpsel_state_t s_q;
    rpsel_state_t s_d;
    logic t2_mux;
    logic t3_mux;
    logic ss_mux;
    logic map_wr;

    // output map register index for an address, or all ones when not one
    function automatic logic [`RPSEL_ADDR_W-1:0] out_index(input logic [`RPSEL_ADDR_W-1:0] a);
        if (a >= `RPSEL_ADDR_OUT_BASE && 32'(a - `RPSEL_ADDR_OUT_BASE) < `RPSEL_NUM_PINS)
        begin
            return a - `RPSEL_ADDR_OUT_BASE;
        end
        return '1;
    endfunction

    // one mux per peripheral input, independent of the output maps
    rpsel_in_mux u_t2_mux (
        .i_pins(i_pin_in),
        .i_sel(s_q.t2_sel),
        .o_in(t2_mux)
    );
    rpsel_in_mux u_t3_mux (
        .i_pins(i_pin_in),
        .i_sel(s_q.t3_sel),
        .o_in(t3_mux)
    );
    rpsel_in_mux u_ss_mux (
        .i_pins(i_pin_in),
        .i_sel(s_q.ss_sel),
        .o_in(ss_mux)
    );

    // map writes pass only while unlocked; the key sequence itself is always heard
    assign map_wr = i_wr && (s_q.lock == RPSEL_OPEN);

    always_comb
    begin
        logic [`RPSEL_ADDR_W-1:0] oi;
        oi = out_index(i_addr);
        s_d = s_q;
        // lock sequencing: two keys in a row open, lock key closes
        if (i_wr && i_addr == `RPSEL_ADDR_LOCK)
        begin
            case (s_q.lock)
                RPSEL_LOCKED:
                begin
                    s_d.lock = (i_wdata == `RPSEL_UNLOCK_KEY1) ? RPSEL_KEY1 : RPSEL_LOCKED;
                end
                RPSEL_KEY1:
                begin
                    s_d.lock = (i_wdata == `RPSEL_UNLOCK_KEY2) ? RPSEL_OPEN : RPSEL_LOCKED;
                end
                RPSEL_OPEN:
                begin
                    s_d.lock = (i_wdata == `RPSEL_LOCK_KEY) ? RPSEL_LOCKED : RPSEL_OPEN;
                end
                default:
                begin
                    s_d.lock = RPSEL_LOCKED;
                end
            endcase
        end
        else if (i_wr && s_q.lock == RPSEL_KEY1)
        begin
            // any other write breaks the sequence
            s_d.lock = RPSEL_LOCKED;
        end
        if (map_wr && i_addr == `RPSEL_ADDR_TMR)
        begin
            s_d.t2_sel = i_wdata[`RPSEL_T2_LSB +: `RPSEL_SEL_W];
            s_d.t3_sel = i_wdata[`RPSEL_T3_LSB +: `RPSEL_SEL_W];
        end
        if (map_wr && i_addr == `RPSEL_ADDR_SPI)
        begin
            s_d.ss_sel = i_wdata[`RPSEL_SS_LSB +: `RPSEL_SEL_W];
        end
        if (map_wr && oi != '1)
        begin
            s_d.out_sel[oi[4:0]] = i_wdata[`RPSEL_POUT_W-1:0];
        end
        // read data valid only in the cycle after the strobe
        s_d.rdata = '0;
        if (i_rd)
        begin
            if (i_addr == `RPSEL_ADDR_TMR)
            begin
                s_d.rdata[`RPSEL_T2_LSB +: `RPSEL_SEL_W] = s_q.t2_sel;
                s_d.rdata[`RPSEL_T3_LSB +: `RPSEL_SEL_W] = s_q.t3_sel;
            end
            else if (i_addr == `RPSEL_ADDR_SPI)
            begin
                s_d.rdata[`RPSEL_SS_LSB +: `RPSEL_SEL_W] = s_q.ss_sel;
            end
            else if (i_addr == `RPSEL_ADDR_LOCK)
            begin
                s_d.rdata[0] = (s_q.lock != RPSEL_OPEN);
            end
            else if (oi != '1)
            begin
                s_d.rdata[`RPSEL_POUT_W-1:0] = s_q.out_sel[oi[4:0]];
            end
        end
        // registered peripheral inputs
        s_d.t2_in = t2_mux;
        s_d.t3_in = t3_mux;
        s_d.ss_in = ss_mux;
        // output side: selector zero leaves the pin with its port
        for (int p = 0; p < `RPSEL_NUM_PINS; p++)
        begin
            if (s_q.out_sel[p] == `RPSEL_OUT_RESET)
            begin
                s_d.pin_out[p] = i_port_out[p];
                s_d.pin_oe[p] = i_port_oe[p];
            end
            else
            begin
                s_d.pin_out[p] = i_periph_out[s_q.out_sel[p]];
                s_d.pin_oe[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q <= '0;
            s_q.t2_sel <= `RPSEL_IN_RESET;
            s_q.t3_sel <= `RPSEL_IN_RESET;
            s_q.ss_sel <= `RPSEL_IN_RESET;
            s_q.lock <= RPSEL_OPEN;
        end
        else if (i_clk_en)
        begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_pin_out = s_q.pin_out;
    assign o_pin_oe = s_q.pin_oe;
    assign o_timer2_external_clock_input = s_q.t2_in;
    assign o_timer3_external_clock_input = s_q.t3_in;
    assign o_spi1_slave_select_input = s_q.ss_in;
    assign o_map_locked = (s_q.lock != RPSEL_OPEN);
    generate
        for (genvar g = 0; g < `RPSEL_NUM_PINS; g++)
        begin : g_remap
            assign o_pin_remapped[g] = (s_q.out_sel[g] != `RPSEL_OUT_RESET);
        end
    endgenerate

    // assertions: lock sequencing and clock enable
    locked_no_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock == RPSEL_LOCKED && i_wr && i_addr == `RPSEL_ADDR_SPI)
        |=> $stable(s_q.ss_sel)) else $error("spi map changed while locked");

    unlock_seq_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock == RPSEL_KEY1 && i_wr && i_addr == `RPSEL_ADDR_LOCK
        && i_wdata == `RPSEL_UNLOCK_KEY2) |=> !o_map_locked)
        else $error("unlock sequence did not open");

    key_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock == RPSEL_LOCKED && i_wr && i_addr == `RPSEL_ADDR_LOCK
        && i_wdata == `RPSEL_UNLOCK_KEY1) |=> s_q.lock == RPSEL_KEY1)
        else $error("first key not taken");

    key_break_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock == RPSEL_KEY1 && i_wr && i_addr != `RPSEL_ADDR_LOCK)
        |=> s_q.lock == RPSEL_LOCKED)
        else $error("stray write did not break unlock");

    relock_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock == RPSEL_OPEN && i_wr && i_addr == `RPSEL_ADDR_LOCK
        && i_wdata == `RPSEL_LOCK_KEY) |=> o_map_locked)
        else $error("lock key did not lock");

    lock_onehot_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        $onehot(s_q.lock))
        else $error("lock state not one-hot");

    locked_tmr_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock != RPSEL_OPEN && i_wr && i_addr == `RPSEL_ADDR_TMR)
        |=> $stable(s_q.t2_sel) && $stable(s_q.t3_sel))
        else $error("timer map changed while locked");

    locked_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.lock != RPSEL_OPEN && i_wr) |=> $stable(s_q.out_sel))
        else $error("output map changed while locked");

    clk_en_freeze_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (!i_clk_en) |=> $stable(s_q))
        else $error("state moved with clock enable low");

    // assertions: read port
    spi_upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_SPI) |=> o_rdata[15:5] == '0)
        else $error("spi map upper bits not zero");

    spi_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_SPI) |=> o_rdata[4:0] == $past(s_q.ss_sel))
        else $error("spi map read wrong");

    tmr_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_TMR) |=> o_rdata[4:0] == $past(s_q.t2_sel))
        else $error("timer2 field read wrong");

    tmr_rd_hi_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_TMR) |=> o_rdata[12:8] == $past(s_q.t3_sel))
        else $error("timer3 field read wrong");

    tmr_rd_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_TMR)
        |=> o_rdata[7:5] == '0 && o_rdata[15:13] == '0)
        else $error("timer map spare bits not zero");

    lock_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_LOCK) |=> o_rdata[0] == $past(o_map_locked))
        else $error("lock read wrong");

    out_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && i_addr == `RPSEL_ADDR_OUT_BASE)
        |=> o_rdata[2:0] == $past(s_q.out_sel[0]) && o_rdata[15:3] == '0)
        else $error("output map read wrong");

    rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && !i_rd) |=> o_rdata == '0)
        else $error("read data stood without a read");

    bad_addr_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_rd && 32'(i_addr) >= `RPSEL_ADDR_OUT_BASE + `RPSEL_NUM_PINS)
        |=> o_rdata == '0)
        else $error("unmapped address read not zero");

    // assertions: map writes
    spi_wr_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && map_wr && i_addr == `RPSEL_ADDR_SPI) |=> s_q.ss_sel == $past(i_wdata[4:0]))
        else $error("spi map write lost");

    t2_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && map_wr && i_addr == `RPSEL_ADDR_TMR) |=> s_q.t2_sel == $past(i_wdata[4:0]))
        else $error("timer2 map write lost");

    t3_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && map_wr && i_addr == `RPSEL_ADDR_TMR) |=> s_q.t3_sel == $past(i_wdata[12:8]))
        else $error("timer3 map write lost");

    out_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && map_wr && i_addr == `RPSEL_ADDR_OUT_BASE)
        |=> s_q.out_sel[0] == $past(i_wdata[2:0]))
        else $error("output map write lost");

    out_keeps_in_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && map_wr && i_addr == `RPSEL_ADDR_OUT_BASE)
        |=> $stable(s_q.t2_sel) && $stable(s_q.ss_sel))
        else $error("output map write touched an input map");

    in_keeps_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && i_wr && (i_addr == `RPSEL_ADDR_TMR || i_addr == `RPSEL_ADDR_SPI))
        |=> $stable(s_q.out_sel))
        else $error("input map write touched an output map");

    // assertions: input routing
    tie_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.ss_sel == `RPSEL_TIE_LOW) |=> !o_spi1_slave_select_input)
        else $error("tied-low select not low");

    t2_tie_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.t2_sel == `RPSEL_TIE_LOW) |=> !o_timer2_external_clock_input)
        else $error("tied-low timer2 clock not low");

    t3_tie_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.t3_sel == `RPSEL_TIE_LOW) |=> !o_timer3_external_clock_input)
        else $error("tied-low timer3 clock not low");

    t2_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && 32'(s_q.t2_sel) < `RPSEL_NUM_PINS)
        |=> o_timer2_external_clock_input == $past(i_pin_in[s_q.t2_sel]))
        else $error("timer2 clock not routed from selected pin");

    t3_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && 32'(s_q.t3_sel) < `RPSEL_NUM_PINS)
        |=> o_timer3_external_clock_input == $past(i_pin_in[s_q.t3_sel]))
        else $error("timer3 clock not routed from selected pin");

    ss_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && 32'(s_q.ss_sel) < `RPSEL_NUM_PINS)
        |=> o_spi1_slave_select_input == $past(i_pin_in[s_q.ss_sel]))
        else $error("spi select not routed from selected pin");

    bad_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && 32'(s_q.t3_sel) >= `RPSEL_NUM_PINS) |=> !o_timer3_external_clock_input)
        else $error("out-of-range code selected a pin");

    ss_bad_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && 32'(s_q.ss_sel) >= `RPSEL_NUM_PINS) |=> !o_spi1_slave_select_input)
        else $error("out-of-range spi code selected a pin");

    // assertions: output side
    out_port_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.out_sel[0] == `RPSEL_OUT_RESET) |=> o_pin_out[0] == $past(i_port_out[0]))
        else $error("unmapped pin not under port control");

    out_port_oe_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.out_sel[0] == `RPSEL_OUT_RESET) |=> o_pin_oe[0] == $past(i_port_oe[0]))
        else $error("unmapped pin enable not from port");

    remap_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.out_sel[0] != `RPSEL_OUT_RESET) |=> o_pin_oe[0])
        else $error("remapped pin not driven");

    out_periph_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_clk_en && s_q.out_sel[`RPSEL_NUM_PINS-1] != `RPSEL_OUT_RESET)
        |=> o_pin_out[`RPSEL_NUM_PINS-1]
        == $past(i_periph_out[s_q.out_sel[`RPSEL_NUM_PINS-1]]))
        else $error("remapped pin not fed by its peripheral");
endmodule

/* File: rpsel_far_end.sv */
// far side model: remappable pin levels, port drive and peripheral outputs
// assumes the bench supplies the reference clock
`include "rpsel_defines.svh"
module rpsel_far_end
(
    input wire logic i_ref_clk,
    output logic [`RPSEL_NUM_PINS-1:0] o_pin_in,
    output logic [`RPSEL_NUM_PINS-1:0] o_port_out,
    output logic [`RPSEL_NUM_PINS-1:0] o_port_oe,
    output logic [`RPSEL_NUM_POUT-1:0] o_periph_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_pin_in = '0;
        o_port_out = '0;
        o_port_oe = '0;
        o_periph_out = '0;
    end
    // fresh levels every cycle, so a stale selection cannot match by luck
    always @(posedge i_ref_clk)
    begin
        o_pin_in <= 26'($urandom);
        o_port_out <= 26'($urandom);
        o_port_oe <= 26'($urandom);
        o_periph_out <= 8'($urandom);
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the pin select block
// assumes rpsel_far_end drives pins and peripheral outputs each cycle
`include "rpsel_defines.svh"
module tb_top
    import rpsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clk_en = 1'b1;
    logic [25:0] prev_oe;
    logic [2:0] omap [26] = '{default: 3'h0};
    logic [5:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [15:0] rdata, got;
    logic [25:0] pin_in, port_out, port_oe, pin_out, pin_oe, remapped, prev_pins, prev_port;
    logic [7:0] periph_out, prev_per;
    logic t2, t3, ss, locked;
    rpsel_sel_t c2, c3, cs;
    logic [2:0] s;
    int n;
    int fail_count = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        prev_pins <= pin_in;
        prev_port <= port_out;
        prev_oe <= port_oe;
        prev_per <= periph_out;
    end
    rpsel_far_end far (.i_ref_clk(clk), .o_pin_in(pin_in), .o_port_out(port_out),
        .o_port_oe(port_oe), .o_periph_out(periph_out));
    rpsel_top dut (.i_ref_clk(clk), .i_reset_n(reset_n), .i_clk_en(clk_en), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin_in(pin_in),
        .i_port_out(port_out), .i_port_oe(port_oe), .i_periph_out(periph_out),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_remapped(remapped),
        .o_timer2_external_clock_input(t2), .o_timer3_external_clock_input(t3),
        .o_spi1_slave_select_input(ss), .o_map_locked(locked));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // codes past the last pin give a low, like the all-ones code
    function automatic logic exp_in(input logic [25:0] p, input rpsel_sel_t c);
        return (c < 5'd26) ? p[c] : 1'b0;
    endfunction
    task automatic watch_inputs(input int cycles);
        repeat (cycles)
        begin
            @(negedge clk);
            chk("timer2 input", {15'h0, exp_in(prev_pins, c2)}, {15'h0, t2});
            chk("timer3 input", {15'h0, exp_in(prev_pins, c3)}, {15'h0, t3});
            chk("spi select input", {15'h0, exp_in(prev_pins, cs)}, {15'h0, ss});
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        void'($urandom(49));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(`RPSEL_ADDR_TMR, got);
        chk("timer map reset", 16'h1f1f, got);
        rd_reg(`RPSEL_ADDR_SPI, got);
        chk("spi map reset", 16'h001f, got);
        c2 = 5'h1f;
        c3 = 5'h1f;
        cs = 5'h1f;
        watch_inputs(3);
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            c2 = (i < 2) ? 5'(25 * i) : 5'($urandom_range(0, 31));
            c3 = (i == 0) ? 5'd26 : 5'($urandom_range(0, 31));
            cs = 5'($urandom_range(0, 31));
            wr_reg(`RPSEL_ADDR_TMR, {3'h0, c3, 3'h0, c2});
            wr_reg(`RPSEL_ADDR_SPI, {11'h7ff, cs});
            // the registered input follows the new selector one edge after the write lands
            @(posedge clk);
            watch_inputs(4);
            rd_reg(`RPSEL_ADDR_SPI, got);
            chk("spi map", {11'h0, cs}, got);
        end
        $display("test input maps done");
        for (int i = 0; i < 30; i++)
        begin
            n = $urandom_range(0, 25);
            s = 3'($urandom_range(0, 7));
            wr_reg(6'(`RPSEL_ADDR_OUT_BASE + n), {13'h0, s});
            omap[n] = s;
            @(posedge clk);
            @(negedge clk);
            chk("pin remapped", {15'h0, s != 3'h0}, {15'h0, remapped[n]});
            chk("pin drive", {15'h0, (s == 3'h0) ? prev_port[n] : prev_per[s]},
                {15'h0, pin_out[n]});
            chk("pin enable", {15'h0, (s == 3'h0) ? prev_oe[n] : 1'b1},
                {15'h0, pin_oe[n]});
            rd_reg(6'(`RPSEL_ADDR_OUT_BASE + n), got);
            chk("out map", {13'h0, s}, got);
            rd_reg(`RPSEL_ADDR_TMR, got);
            chk("timer map kept", {3'h0, c3, 3'h0, c2}, got);
        end
        $display("test output maps done");
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_LOCK_KEY);
        @(negedge clk);
        chk("locked flag", 16'h0001, {15'h0, locked});
        wr_reg(`RPSEL_ADDR_TMR, 16'h0000);
        rd_reg(`RPSEL_ADDR_TMR, got);
        chk("timer map locked", {3'h0, c3, 3'h0, c2}, got);
        n = $urandom_range(0, 25);
        wr_reg(6'(`RPSEL_ADDR_OUT_BASE + n), 16'h0000);
        rd_reg(6'(`RPSEL_ADDR_OUT_BASE + n), got);
        chk("out map locked", {13'h0, omap[n]}, got);
        // a stray write between the two keys must spoil the unlock
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_UNLOCK_KEY1);
        wr_reg(`RPSEL_ADDR_SPI, 16'h0000);
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_UNLOCK_KEY2);
        rd_reg(`RPSEL_ADDR_LOCK, got);
        chk("lock read", 16'h0001, got);
        rd_reg(`RPSEL_ADDR_SPI, got);
        chk("spi map locked", {11'h0, cs}, got);
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_UNLOCK_KEY1);
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_UNLOCK_KEY2);
        @(negedge clk);
        chk("unlocked flag", 16'h0000, {15'h0, locked});
        wr_reg(`RPSEL_ADDR_TMR, 16'h0000);
        rd_reg(`RPSEL_ADDR_TMR, got);
        chk("timer map open", 16'h0000, got);
        rd_reg(6'h3f, got);
        chk("unmapped read", 16'h0000, got);
        $display("test lock done");
        // a write with the clock enable low must leave the maps alone
        @(posedge clk);
        clk_en <= 1'b0;
        wr_reg(`RPSEL_ADDR_TMR, 16'h1f1f);
        @(posedge clk);
        clk_en <= 1'b1;
        rd_reg(`RPSEL_ADDR_TMR, got);
        chk("timer map frozen", 16'h0000, got);
        $display("test clock enable done");
        wr_reg(`RPSEL_ADDR_LOCK, `RPSEL_LOCK_KEY);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(`RPSEL_ADDR_TMR, got);
        chk("timer map after reset", 16'h1f1f, got);
        chk("lock after reset", 16'h0000, {15'h0, locked});
        $display("test second reset done");
        give_verdict();
    end
endmodule
